/* File: rtl/usc_params.svh */
// constants for the serial status and base clock select block
// assumes inclusion by bare name from every design file that needs them
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

// register addresses on the 16-bit internal bus
`define USC_ADDR_ERR_FLAGS   16'hff53
`define USC_ADDR_TX_STATUS   16'hff55
`define USC_ADDR_CLK_SEL     16'hff56
`define USC_ADDR_RX_BUF      16'hff0a
`define USC_ADDR_TX_BUF      16'hff0b

// field positions
`define USC_BIT_PARITY_ERR   2
`define USC_BIT_FRAMING_ERR  1
`define USC_BIT_OVERRUN      0
`define USC_BIT_BUF_FULL     1
`define USC_BIT_SHIFT_BUSY   0
`define USC_CLK_SEL_MSB      3

// reset values
`define USC_RST_ERR_FLAGS    3'h0
`define USC_RST_CLK_SEL      4'h0
`define USC_RST_RX_BUF       8'hff
`define USC_RST_TX_BUF       8'hff
`define USC_RST_RDATA        8'h00

// base clock selection
`define USC_CLK_SEL_DIV_MAX  4'ha
`define USC_CLK_SEL_TIMER    4'hb
`define USC_DIV_WIDTH        10

`endif

/* File: rtl/usc_pkg.sv */
// types shared by the serial status and base clock select block
// assumes nothing beyond a systemverilog compiler
package usc_pkg;

    typedef enum logic [1:0] {
        USC_PAR_NONE = 2'b00,
        USC_PAR_ZERO = 2'b01,
        USC_PAR_ODD  = 2'b10,
        USC_PAR_EVEN = 2'b11
    } usc_parity_mode_type;

    typedef enum logic [1:0] {
        USC_RD_IDLE  = 2'b00,
        USC_RD_WAIT  = 2'b01
    } usc_rd_state_type;

    typedef logic [7:0] usc_byte_type;

endpackage

/* File: rtl/usc_skid_buf.sv */
// two-entry buffer between the transmit buffer and the line shifter
// assumes one clock and a synchronous active-low reset
`include "usc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module usc_skid_buf (
    input  wire logic  core_clk,
    input  wire logic  rst_n,
    usc_stream_if.snk  in_side,
    usc_stream_if.src  out_side
);
    import usc_pkg::*;

    logic         out_valid_reg;
    usc_byte_type out_data_reg;
    logic         spare_valid_reg;
    usc_byte_type spare_data_reg;
    logic         in_fire;

    // ready comes from a flop only, so the producer never sees a loop through the consumer
    assign in_side.ready  = !spare_valid_reg;
    assign out_side.valid = out_valid_reg;
    assign out_side.data  = out_data_reg;
    assign in_fire        = in_side.valid && !spare_valid_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_valid_reg   <= 1'b0;
            out_data_reg    <= `USC_RST_TX_BUF;
            spare_valid_reg <= 1'b0;
            spare_data_reg  <= `USC_RST_TX_BUF;
        end else if (!out_valid_reg || out_side.ready) begin
            if (spare_valid_reg) begin
                out_valid_reg   <= 1'b1;
                out_data_reg    <= spare_data_reg;
                spare_valid_reg <= 1'b0;
            end else begin
                out_valid_reg <= in_fire;
                if (in_fire) begin
                    out_data_reg <= in_side.data;
                end
            end
        end else if (in_fire) begin
            spare_valid_reg <= 1'b1;
            spare_data_reg  <= in_side.data;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/usc_status_top.sv */
// serial interface status flags, transmit occupancy and base clock select
// assumes the 8-bit internal bus, the mode bits and the receiver on core_clk;
// the timer output arrives from elsewhere and is synchronised here
`include "usc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module usc_status_top (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [15:0]             bus_addr,
    input  wire logic                    bus_rd,
    input  wire logic                    bus_wr,
    input  wire usc_pkg::usc_byte_type   bus_wdata,
    output logic                         bus_ack,
    output logic                         bus_wait,
    output usc_pkg::usc_byte_type        bus_rdata,
    input  wire logic                    operation_enable,
    input  wire logic                    receive_enable,
    input  wire logic                    transmit_enable,
    input  wire logic                    parity_mode_high,
    input  wire logic                    parity_mode_low,
    input  wire logic                    rx_done,
    input  wire usc_pkg::usc_byte_type   rx_data,
    input  wire logic                    rx_parity_bit,
    input  wire logic                    rx_stop_bit,
    input  wire logic                    timer_output_pin,
    output logic                         base_clock_tick,
    output logic                         tx_shift_valid,
    output usc_pkg::usc_byte_type        tx_shift_data,
    input  wire logic                    tx_shift_ready,
    input  wire logic                    tx_frame_done
);
    import usc_pkg::*;

    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] target);
        addr_is = (a == target);
    endfunction

    usc_rd_state_type    rd_state_reg;
    usc_rd_state_type    rd_state_next;
    logic [2:0]          err_flags_reg;
    logic [2:0]          err_snap_reg;
    logic [2:0]          err_set;
    logic [2:0]          err_clr;
    usc_byte_type        rx_buf_reg;
    logic                rx_unread_reg;
    usc_byte_type        tx_buf_reg;
    logic                buf_full_reg;
    logic                shift_busy_reg;
    logic [3:0]          clk_sel_reg;
    logic [`USC_DIV_WIDTH-1:0] div_cnt_reg;
    logic [10:0]         div_tap;
    logic                tick_next;
    logic                tmr_meta_reg;
    logic                tmr_sync_reg;
    logic                tmr_prev_reg;
    logic                tmr_edge;
    logic                rx_active;
    logic                tx_active;
    logic                rx_take;
    logic                parity_calc;
    logic                parity_bad;
    logic                overrun;
    logic                rd_take;
    logic                wr_take;
    logic                rd_rx_buf;
    logic                move;
    usc_parity_mode_type parity_mode;
    usc_byte_type        rd_value;

    usc_stream_if tx_in ();
    usc_stream_if tx_out ();

    assign rx_active   = operation_enable && receive_enable;
    assign tx_active   = operation_enable && transmit_enable;
    assign parity_mode = usc_parity_mode_type'({parity_mode_high, parity_mode_low});

    // bus request decode; a second read is refused while the wait cycle runs
    assign rd_take   = bus_rd && (rd_state_reg == USC_RD_IDLE);
    assign wr_take   = bus_wr && (rd_state_reg == USC_RD_IDLE);
    assign rd_rx_buf = rd_take && addr_is(bus_addr, `USC_ADDR_RX_BUF);

    // reception result
    assign rx_take     = rx_done && rx_active;
    assign parity_calc = ^rx_data;
    always_comb begin
        case (parity_mode)
            USC_PAR_ODD:  parity_bad = (parity_calc ^ rx_parity_bit) != 1'b1;
            USC_PAR_EVEN: parity_bad = (parity_calc ^ rx_parity_bit) != 1'b0;
            USC_PAR_ZERO: parity_bad = 1'b0;
            USC_PAR_NONE: parity_bad = 1'b0;
            default:      parity_bad = 1'b0;
        endcase
    end

    // a byte read out in the very cycle of a new completion counts as read
    assign overrun = rx_unread_reg && !rd_rx_buf;

    always_comb begin
        err_set = 3'h0;
        err_set[`USC_BIT_PARITY_ERR]  = rx_take && parity_bad;
        err_set[`USC_BIT_FRAMING_ERR] = rx_take && !rx_stop_bit;
        err_set[`USC_BIT_OVERRUN]     = rx_take && overrun;
    end

    // only the captured bits are cleared, so an event after the capture survives
    assign err_clr = (rd_state_reg == USC_RD_WAIT) ? err_snap_reg : 3'h0;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            err_flags_reg <= `USC_RST_ERR_FLAGS;
        end else if (!operation_enable) begin
            err_flags_reg <= `USC_RST_ERR_FLAGS;
        end else begin
            // set wins over the read clear
            err_flags_reg <= (err_flags_reg & ~err_clr) | err_set;
        end
    end

    // receive buffer with its unread marker
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_buf_reg    <= `USC_RST_RX_BUF;
            rx_unread_reg <= 1'b0;
        end else if (!operation_enable) begin
            rx_buf_reg    <= `USC_RST_RX_BUF;
            rx_unread_reg <= 1'b0;
        end else if (rx_take && !overrun) begin
            rx_buf_reg    <= rx_data;
            rx_unread_reg <= 1'b1;
        end else if (rd_rx_buf) begin
            rx_unread_reg <= 1'b0;
        end
        // on overrun the older byte stays put
    end

    // transmit buffer and occupancy
    assign move = buf_full_reg && tx_in.ready && tx_active
                  && (!shift_busy_reg || tx_frame_done);
    assign tx_in.valid = move;
    assign tx_in.data  = tx_buf_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_buf_reg <= `USC_RST_TX_BUF;
        end else if (wr_take && addr_is(bus_addr, `USC_ADDR_TX_BUF)) begin
            tx_buf_reg <= bus_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            buf_full_reg <= 1'b0;
        end else if (!tx_active) begin
            buf_full_reg <= 1'b0;
        end else if (wr_take && addr_is(bus_addr, `USC_ADDR_TX_BUF)) begin
            buf_full_reg <= 1'b1;
        end else if (move) begin
            buf_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shift_busy_reg <= 1'b0;
        end else if (!tx_active) begin
            shift_busy_reg <= 1'b0;
        end else if (move) begin
            shift_busy_reg <= 1'b1;
        end else if (tx_frame_done) begin
            shift_busy_reg <= 1'b0;
        end
    end

    // a stall by the line shifter fills the spare entry and drops its ready, so no byte enters this buffer and buffer-full holds high
    usc_skid_buf u_skid (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .in_side  (tx_in),
        .out_side (tx_out)
    );

    assign tx_shift_valid = tx_out.valid;
    assign tx_shift_data  = tx_out.data;
    assign tx_out.ready   = tx_shift_ready;

    // base clock select register; writing the same value touches no counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clk_sel_reg <= `USC_RST_CLK_SEL;
        end else if (wr_take && addr_is(bus_addr, `USC_ADDR_CLK_SEL)) begin
            clk_sel_reg <= bus_wdata[`USC_CLK_SEL_MSB:0];
        end
    end

    // free-running divider, cleared to zero while the unit is off
    always_ff @(posedge core_clk) begin
        if (!rst_n || !operation_enable) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    assign div_tap[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 1; gi <= 10; gi++) begin : g_tap
            assign div_tap[gi] = &div_cnt_reg[gi-1:0];
        end
    endgenerate

    // timer output comes from outside this clock's control, two flops first
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tmr_meta_reg <= 1'b0;
            tmr_sync_reg <= 1'b0;
            tmr_prev_reg <= 1'b0;
        end else begin
            tmr_meta_reg <= timer_output_pin;
            tmr_sync_reg <= tmr_meta_reg;
            tmr_prev_reg <= tmr_sync_reg;
        end
    end
    assign tmr_edge = tmr_sync_reg && !tmr_prev_reg;

    always_comb begin
        if (clk_sel_reg <= `USC_CLK_SEL_DIV_MAX) begin
            tick_next = div_tap[clk_sel_reg];
        end else if (clk_sel_reg == `USC_CLK_SEL_TIMER) begin
            tick_next = tmr_edge;
        end else begin
            tick_next = 1'b0; // prohibited codes give no base clock
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            base_clock_tick <= 1'b0;
        end else begin
            base_clock_tick <= tick_next && operation_enable;
        end
    end

    // register read mux; upper bits of every status register read zero
    always_comb begin
        rd_value = `USC_RST_RDATA;
        if (addr_is(bus_addr, `USC_ADDR_TX_STATUS)) begin
            rd_value[`USC_BIT_BUF_FULL]   = buf_full_reg;
            rd_value[`USC_BIT_SHIFT_BUSY] = shift_busy_reg;
        end else if (addr_is(bus_addr, `USC_ADDR_CLK_SEL)) begin
            rd_value[`USC_CLK_SEL_MSB:0] = clk_sel_reg;
        end else if (addr_is(bus_addr, `USC_ADDR_RX_BUF)) begin
            rd_value = rx_buf_reg;
        end else if (addr_is(bus_addr, `USC_ADDR_TX_BUF)) begin
            rd_value = tx_buf_reg;
        end
    end

    // read state machine: only the error register takes the extra cycle
    always_comb begin
        case (rd_state_reg)
            USC_RD_IDLE: begin
                if (rd_take && addr_is(bus_addr, `USC_ADDR_ERR_FLAGS)) begin
                    rd_state_next = USC_RD_WAIT;
                end else begin
                    rd_state_next = USC_RD_IDLE;
                end
            end
            USC_RD_WAIT: rd_state_next = USC_RD_IDLE;
            default:     rd_state_next = USC_RD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_state_reg <= USC_RD_IDLE;
        end else begin
            rd_state_reg <= rd_state_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            err_snap_reg <= `USC_RST_ERR_FLAGS;
        end else if (rd_take && addr_is(bus_addr, `USC_ADDR_ERR_FLAGS)) begin
            err_snap_reg <= err_flags_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_wait <= 1'b0;
        end else begin
            bus_wait <= rd_take && addr_is(bus_addr, `USC_ADDR_ERR_FLAGS);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_ack   <= 1'b0;
            bus_rdata <= `USC_RST_RDATA;
        end else if (rd_state_reg == USC_RD_WAIT) begin
            bus_ack   <= 1'b1;
            bus_rdata <= {5'h00, err_snap_reg};
        end else if (rd_take && !addr_is(bus_addr, `USC_ADDR_ERR_FLAGS)) begin
            bus_ack   <= 1'b1;
            bus_rdata <= rd_value;
        end else begin
            // writes to the status registers land here and change nothing
            bus_ack   <= wr_take;
            bus_rdata <= `USC_RST_RDATA;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/usc_stream_if.sv */
// byte stream with valid and ready between the block's own modules
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none
interface usc_stream_if;
    import usc_pkg::*;
    logic         valid;
    logic         ready;
    usc_byte_type data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the status and base clock select block
// assumes design, checker and line model compiled first; 25 MHz core_clk
`include "usc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import usc_pkg::*;
    logic         core_clk, rst_n, bus_rd, bus_wr, bus_ack, bus_wait, slow;
    logic [15:0]  bus_addr;
    usc_byte_type bus_wdata, bus_rdata, rx_data, tx_shift_data, q, m_fl, m_rx;
    logic         operation_enable, receive_enable, transmit_enable, rx_done;
    logic         parity_mode_high, parity_mode_low, rx_parity_bit, rx_stop_bit;
    logic         timer_output_pin, base_clock_tick, tx_shift_valid, tx_shift_ready;
    logic         tx_frame_done, m_unread;
    int           num_errors, total_checks, ticks, saw_full, k;
    usc_byte_type sent[$];

    usc_status_top u_usc_status_top (.core_clk, .rst_n, .bus_addr, .bus_rd, .bus_wr,
        .bus_wdata, .bus_ack, .bus_wait, .bus_rdata, .operation_enable, .receive_enable,
        .transmit_enable, .parity_mode_high, .parity_mode_low, .rx_done, .rx_data,
        .rx_parity_bit, .rx_stop_bit, .timer_output_pin, .base_clock_tick,
        .tx_shift_valid, .tx_shift_data, .tx_shift_ready, .tx_frame_done);
    usc_line_model u_usc_line_model (.core_clk, .rst_n, .slow, .tx_shift_valid,
        .tx_shift_data, .tx_shift_ready, .tx_frame_done);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic fail_line(input int a, input int b);
        num_errors++;
        $display("[FAIL] %0t got %0h expected %0h", $time, a, b);
    endtask
    task automatic chk(input usc_byte_type got, input usc_byte_type exp);
        total_checks++;
        if (got !== exp) fail_line(got, exp);
    endtask
    task automatic chk_n(input int got, input int exp);
        total_checks++;
        if (got != exp) fail_line(got, exp);
    endtask
    // one strobe cycle, then wait for the ack under a bound
    task automatic bus(input logic w, input logic [15:0] a, input usc_byte_type d);
        int n = 0;
        @(posedge core_clk);
        bus_rd    <= !w;
        bus_wr    <= w;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
        @(negedge core_clk);
        while (bus_ack !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 4) fail_line(0, 1);
        q = bus_rdata;
    endtask
    task automatic rd(input logic [15:0] a, input usc_byte_type exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic rd_fl;
        rd(`USC_ADDR_ERR_FLAGS, m_fl);
        m_fl = 8'h00;
    endtask
    task automatic rd_rx;
        rd(`USC_ADDR_RX_BUF, m_rx);
        m_unread = 1'b0;
    endtask
    task automatic rx(input usc_byte_type d, input logic p, input logic s);
        logic [1:0] pm;
        logic       pe;
        @(posedge core_clk);
        {rx_done, rx_data, rx_parity_bit, rx_stop_bit} <= {1'b1, d, p, s};
        @(posedge core_clk);
        {rx_done, rx_data, rx_parity_bit, rx_stop_bit} <= {1'b0, ~d, ~p, ~s};
        pm = {parity_mode_high, parity_mode_low};
        pe = pm[1] && (p != (pm[0] ? ^d : ~^d));
        if (operation_enable && receive_enable) begin
            m_fl = m_fl | {5'h00, pe, !s, m_unread};
            if (!m_unread) m_rx = d;
            m_unread = 1'b1;
        end
    endtask
    task automatic wr_tx(input usc_byte_type d);
        int n = 0;
        do begin
            bus(1'b0, `USC_ADDR_TX_STATUS, 8'h00);
            n++;
        end while (q[1] !== 1'b0 && n < 400);
        if (n > 1) saw_full = 1;
        sent.push_back(d);
        bus(1'b1, `USC_ADDR_TX_BUF, d);
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        final_report;
    end

    initial begin
        {rst_n, bus_rd, bus_wr, bus_addr, bus_wdata, slow, rx_done, rx_data} = '0;
        {operation_enable, receive_enable, transmit_enable, timer_output_pin} = '0;
        {parity_mode_high, parity_mode_low, rx_parity_bit, rx_stop_bit} = '0;
        {m_fl, m_unread, saw_full} = '0;
        m_rx = 8'hff;
        void'($urandom(87));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_fl;
        rd(`USC_ADDR_TX_STATUS, 8'h00);
        rd(`USC_ADDR_CLK_SEL, 8'h00);
        rd(16'hff00, 8'h00);
        rd_rx;
        // code 12 is prohibited and must give no base clock at all
        for (int c = 0; c <= 12; c++) begin
            @(posedge core_clk);
            operation_enable <= 1'b0;
            bus(1'b1, `USC_ADDR_CLK_SEL, {4'($urandom), 4'(c)});
            rd(`USC_ADDR_CLK_SEL, 8'(c));
            @(posedge core_clk);
            operation_enable <= 1'b1;
            ticks = 0;
            repeat (16) @(posedge core_clk);
            fork
                for (int n = 0; n < 1024; n++) begin
                    @(negedge core_clk);
                    if (base_clock_tick === 1'b1) ticks++;
                end
                begin
                    repeat (300) @(posedge core_clk);
                    bus(1'b1, `USC_ADDR_CLK_SEL, 8'(c));
                    repeat (8) begin
                        @(posedge core_clk);
                        timer_output_pin <= 1'b1;
                        repeat (10) @(posedge core_clk);
                        timer_output_pin <= 1'b0;
                        repeat (10) @(posedge core_clk);
                    end
                end
            join
            chk_n(ticks, c == 12 ? 0 : c == 11 ? 8 : 1024 >> c);
        end
        @(posedge core_clk);
        receive_enable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            {parity_mode_high, parity_mode_low} <= 2'(i);
            rx(8'($urandom), 1'($urandom), 1'($urandom));
            if ($urandom % 3 == 0) rx(8'($urandom), 1'b0, 1'b1);
            rd_fl;
            if (i % 2 == 0) rd_rx;
        end
        rd_fl;
        rx(8'h5a, 1'b0, 1'b0);
        bus(1'b1, `USC_ADDR_ERR_FLAGS, 8'h00);
        rd_fl;
        rx(8'h3c, 1'b0, 1'b0);
        @(posedge core_clk);
        operation_enable <= 1'b0;
        @(posedge core_clk);
        {m_fl, m_unread, m_rx} = {8'h00, 1'b0, 8'hff};
        rx(8'h33, 1'b0, 1'b0);
        rd_fl;
        rd_rx;
        @(posedge core_clk);
        {operation_enable, transmit_enable} <= 2'b11;
        for (int b = 0; b < 10; b++) begin
            @(posedge core_clk);
            slow <= (b >= 5);
            wr_tx(8'($urandom));
        end
        k = 0;
        do begin
            bus(1'b0, `USC_ADDR_TX_STATUS, 8'h00);
            k++;
        end while (q !== 8'h00 && k < 2000);
        chk(q, 8'h00);
        chk_n(u_usc_line_model.got.size(), sent.size());
        foreach (sent[i]) chk(u_usc_line_model.got[i], sent[i]);
        chk_n(u_usc_line_model.gap_bad, 0);
        chk_n(saw_full, 1);
        wr_tx(8'ha5);
        wr_tx(8'h5a);
        @(posedge core_clk);
        transmit_enable <= 1'b0;
        @(posedge core_clk);
        rd(`USC_ADDR_TX_STATUS, 8'h00);
        final_report;
    end
endmodule
`default_nettype wire

/* File: test/usc_checker.sv */
// concurrent checks on the ports of the status and base clock select block
// assumes a bind onto usc_status_top; one clock, synchronous active-low reset
`include "usc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module usc_checker (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic [15:0]           bus_addr,
    input wire logic                  bus_rd,
    input wire logic                  bus_wr,
    input wire logic                  bus_ack,
    input wire logic                  bus_wait,
    input wire usc_pkg::usc_byte_type bus_rdata,
    input wire logic                  operation_enable,
    input wire logic                  transmit_enable,
    input wire logic                  base_clock_tick,
    input wire logic                  tx_shift_valid,
    input wire usc_pkg::usc_byte_type tx_shift_data,
    input wire logic                  tx_shift_ready
);
    import usc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic err_rd;
    logic st_rd;
    logic plain_req;
    assign err_rd    = bus_rd && bus_addr == `USC_ADDR_ERR_FLAGS && !bus_wait;
    assign st_rd     = bus_rd && bus_addr == `USC_ADDR_TX_STATUS && !bus_wait;
    assign plain_req = (bus_rd || bus_wr) && !bus_wait && !err_rd;
    sequence wait_then_ack;
        bus_wait && !bus_ack ##1 bus_ack && !bus_wait;
    endsequence
    sequence disabled_read;
        !operation_enable ##1 err_rd && !operation_enable;
    endsequence
    err_wait_a: assert property (err_rd |=> wait_then_ack)
        else $error("error register read without one wait cycle");
    wait_cause_a: assert property (bus_wait |-> $past(err_rd))
        else $error("wait cycle without error register read");
    plain_ack_a: assert property (plain_req |=> bus_ack && !bus_wait)
        else $error("plain access not acked next cycle");
    ack_cause_a: assert property (bus_ack |-> $past(bus_wait) || $past(plain_req))
        else $error("ack without request");
    flags_off_a: assert property (disabled_read |=> ##1 bus_rdata == 8'h00)
        else $error("error flags not zero while disabled");
    err_high_a: assert property (err_rd |=> ##1 bus_rdata[7:3] == 5'h00)
        else $error("error register high bits not zero");
    status_high_a: assert property (st_rd |=> bus_rdata[7:2] == 6'h00)
        else $error("status register high bits not zero");
    tick_off_a: assert property (!operation_enable [*4] |-> !base_clock_tick)
        else $error("base clock runs while unit disabled");
    shift_hold_a: assert property (tx_shift_valid && !tx_shift_ready
        && operation_enable && transmit_enable |=> tx_shift_valid && $stable(tx_shift_data))
        else $error("offered byte dropped or changed before taken");
endmodule
bind usc_status_top usc_checker u_usc_checker (.core_clk, .rst_n, .bus_addr, .bus_rd,
    .bus_wr, .bus_ack, .bus_wait, .bus_rdata, .operation_enable, .transmit_enable,
    .base_clock_tick, .tx_shift_valid, .tx_shift_data, .tx_shift_ready);
`default_nettype wire

/* File: test/usc_line_model.sv */
// line shifter model on the far side of the transmit path
// assumes core_clk domain; slow lengthens frames so the buffer fills
`timescale 1ns/1ns
`default_nettype none
module usc_line_model (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  slow,
    input  wire logic                  tx_shift_valid,
    input  wire usc_pkg::usc_byte_type tx_shift_data,
    output logic                       tx_shift_ready,
    output logic                       tx_frame_done
);
    import usc_pkg::*;
    usc_byte_type got[$];
    int           left;
    int           idle;
    int           gap_bad;
    logic         after_fd;
    // slow frames also keep ready low for two idle cycles, so the offer must stand
    assign tx_shift_ready = (left == 0) && rst_n && (!slow || idle >= 2);
    always @(posedge core_clk) begin
        tx_frame_done <= 1'b0;
        if (!rst_n) begin
            left     <= 0;
            after_fd <= 1'b0;
        end else if (tx_shift_valid && tx_shift_ready) begin
            got.push_back(tx_shift_data);
            left <= slow ? 200 : 30;
            if (!slow && after_fd && idle > 3) gap_bad <= gap_bad + 1;
            idle <= 0;
        end else if (left > 1) begin
            left <= left - 1;
        end else if (left == 1) begin
            left          <= 0;
            tx_frame_done <= 1'b1;
            after_fd      <= 1'b1;
        end else begin
            idle <= idle + 1;
        end
    end
endmodule
`default_nettype wire
